// ===== verilog/charger_mode_pkg.sv
// Constants, register map and carrier types of the charger mode control block.
package charger_mode_pkg;
	// Register offsets.
	localparam logic [7:0] REG_GLOBAL = 8'h00;
	localparam logic [7:0] REG_OPER   = 8'h01;
	localparam logic [7:0] REG_POWER  = 8'h02;
	localparam logic [7:0] REG_ROUTE  = 8'h0d;
	localparam logic [7:0] REG_ADAPT  = 8'h19;
	localparam logic [7:0] REG_DROP   = 8'h1a;
	localparam logic [7:0] REG_STATUS = 8'h42;
	// Field positions.
	localparam int B_REG_RESET = 7;
	localparam int B_FREQ      = 7;
	localparam int B_PIN_EN    = 1;
	localparam int B_OP_MODE   = 0;
	localparam int B_SHIP      = 7;
	localparam int B_SHIP_DLY  = 6;
	localparam int B_ROUTE     = 1;
	localparam int B_ASIG_EN   = 7;
	localparam int B_ASIG_DIR  = 6;
	localparam int B_ASIG_DONE = 0;
	localparam int B_STAT_BST  = 3;
	localparam int B_STAT_ADC  = 0;
	localparam int F_STATE_LSB = 6;
	localparam int F_RES_LSB   = 3;
	localparam int F_CLAMP_LSB = 0;
	// Values after reset.
	localparam logic [7:0] RST_GLOBAL = 8'h00;
	localparam logic [7:0] RST_OPER   = 8'h00;
	localparam logic [7:0] RST_POWER  = 8'h00;
	localparam logic [7:0] RST_ROUTE  = 8'h00;
	localparam logic [7:0] RST_ADAPT  = 8'h00;
	localparam logic [7:0] RST_DROP   = 8'h00;
	// Times and the cycle counts derived from them.
	localparam int CLK_HZ          = 25_000_000;
	localparam int CYC_PER_MS      = CLK_HZ / 1000;
	localparam int WAKE_MS         = 1000;
	localparam int SHIP_SHORT_MS   = 10;
	localparam int SHIP_LONG_MS    = 1000;
	localparam int PULSE_LONG_MS   = 100;
	localparam int PULSE_SHORT_MS  = 50;
	localparam int PULSE_GAP_MS    = 50;
	localparam int WAKE_CYC        = WAKE_MS * CYC_PER_MS;
	localparam int SHIP_SHORT_CYC  = SHIP_SHORT_MS * CYC_PER_MS;
	localparam int SHIP_LONG_CYC   = SHIP_LONG_MS * CYC_PER_MS;
	localparam int PULSE_LONG_CYC  = PULSE_LONG_MS * CYC_PER_MS;
	localparam int PULSE_SHORT_CYC = PULSE_SHORT_MS * CYC_PER_MS;
	localparam int PULSE_GAP_CYC   = PULSE_GAP_MS * CYC_PER_MS;
	localparam logic [1:0] PULSE_NUM = 2'h3;
	// Analog scaling.
	localparam int REGULATED_CHARGE_VOLTAGE_STEP_MV = 200;
	localparam int RES_STEP_MOHM = 25;
	localparam int CLAMP_STEP_MV = 32;

	typedef struct packed {
		logic [7:0] reset_ctl;
		logic [7:0] oper;
		logic [7:0] power;
		logic [7:0] route;
		logic [7:0] adapt;
		logic [7:0] drop;
	} ctrl_regs_t;
	typedef enum logic [2:0] {I_IDLE = 3'b001, I_RX = 3'b010, I_TX = 3'b100} bus_state_t;
	typedef enum logic [2:0] {S_RUN = 3'b001, S_DELAY = 3'b010, S_OFF = 3'b100} ship_state_t;
	typedef enum logic [2:0] {P_IDLE = 3'b001, P_ON = 3'b010, P_GAP = 3'b100} pump_state_t;
	typedef enum logic [4:0] {
		Z_COLD = 5'b00001, Z_COOL = 5'b00010, Z_NORMAL = 5'b00100, Z_WARM = 5'b01000, Z_HOT = 5'b10000
	} zone_t;
	typedef struct packed {
		zone_t zone;
		logic  charge_stop;
		logic  current_half;
		logic  voltage_drop;
	} thermal_t;
endpackage

// ===== verilog/charger_mode_control.sv
// Charger mode control: register slave, boost, shipping, adapter signalling, thermal zones.
// What this block does
// - Switching frequency bit applies whether boost is running or not.
// - Software control: operation mode bit starts boost operation.
// - Pin control enabled with operation mode bit set: boost follows the boost control pin level.
// - Boost with routing bit set drives the bus input rail.
// - Boost with routing bit clear drives the intermediate power node.
// - Storage bit set shuts internal circuits down.
// - Delay select bit chooses battery switch turn-off delay in storage mode.
// - Input power or clearing the bit ends storage mode.
// - Wake button high-to-low press within one second ends storage mode.
// - Register reset bit restores all defaults, ending storage mode too.
// - Enabled adapter write starts an up or down current pulse pattern.
// - Pattern completion raises the interrupt output for the host.
// - Warm zone lowers regulated charge voltage by a fixed step.
// - Cool zone halves the constant-current charge current.
// - Colder than first or hotter than fourth threshold stops charging.
// - Cold-side comparators trip on rising ratio, hysteresis done outside.
// - Hot-side comparators trip on falling ratio, hysteresis done outside.
// - Compensation adds the lesser of current times resistance and clamp.
// - Status register shows charger state, boost state and converter activity.
`timescale 1ns/1ps
module charger_mode_control import charger_mode_pkg::*; #(
	parameter logic [6:0] DEV_ADDR     = 7'h5a, // Arbitrary value.
	parameter int CNT_W                = 25,
	parameter int WAKE_CYCLES          = WAKE_CYC,
	parameter int SHIP_SHORT_CYCLES    = SHIP_SHORT_CYC,
	parameter int SHIP_LONG_CYCLES     = SHIP_LONG_CYC,
	parameter int PULSE_LONG_CYCLES    = PULSE_LONG_CYC,
	parameter int PULSE_SHORT_CYCLES   = PULSE_SHORT_CYC,
	parameter int PULSE_GAP_CYCLES     = PULSE_GAP_CYC
) (
	// Clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// Two-wire register port.
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// Host pins and power sense.
	input  wire logic        boost_pin,
	input  wire logic        wake_button_pin,
	input  wire logic        input_power_present,
	// Thermistor comparators and charger state.
	input  wire logic        cold_t1,
	input  wire logic        cool_t2,
	input  wire logic        warm_t3,
	input  wire logic        hot_t4,
	input  wire logic [1:0]  charger_state_field,
	input  wire logic        adc_busy,
	input  wire logic [12:0] charge_current_ma,
	// Power stage controls.
	output logic             switch_frequency_select,
	output logic             boost_active,
	output logic             boost_on_bus_rail,
	output logic             boost_on_mid_node,
	output logic             internal_shutdown,
	output logic             battery_switch_off,
	output logic             input_current_pulse,
	output logic             adapter_irq,
	output thermal_t         thermal,
	output logic [10:0]      drop_comp_mv
);
	if (CNT_W < 2 || CNT_W > 31 || WAKE_CYCLES < 1 || SHIP_SHORT_CYCLES < 1 || SHIP_LONG_CYCLES < 1
		|| PULSE_LONG_CYCLES < 1 || PULSE_SHORT_CYCLES < 1 || PULSE_GAP_CYCLES < 1
		|| WAKE_CYCLES >= 2**CNT_W || SHIP_LONG_CYCLES >= 2**CNT_W || SHIP_SHORT_CYCLES >= 2**CNT_W
		|| PULSE_LONG_CYCLES >= 2**CNT_W || PULSE_SHORT_CYCLES >= 2**CNT_W || PULSE_GAP_CYCLES >= 2**CNT_W) begin : g_chk
		$error("charger_mode_control: counts do not fit CNT_W");
	end

	ctrl_regs_t        regs, next_regs;
	bus_state_t        bst, next_bst;
	ship_state_t       sst, next_sst;
	pump_state_t       pst, next_pst;
	logic              scl_q, sda_q;
	logic [3:0]        bcnt, next_bcnt;
	logic [7:0]        sh, next_sh, ptr, next_ptr;
	logic [1:0]        kind, next_kind;
	logic              rnw, next_rnw, drive, next_drive, wr_en, rd_strobe;
	logic [CNT_W-1:0]  scnt, next_scnt, wcnt, next_wcnt, pcnt, next_pcnt;
	logic              wake_q, pressed, next_pressed, wake_exit;
	logic [1:0]        pn, next_pn;
	logic              done_flag, next_done_flag, pump_done, pump_start;
	logic              next_freq, next_boost, next_bus, next_mid, next_irq;
	thermal_t          next_thermal;
	logic [20:0]       ir_mv_x1000;
	logic [10:0]       ir_mv, clamp_mv, next_comp;
	logic              rise, fall, start_c, stop_c;

	// Read view of the register map; unmapped offsets read as zero.
	function automatic logic [7:0] read_reg(input logic [7:0] a);
		case (a)
			REG_GLOBAL: read_reg = regs.reset_ctl;
			REG_OPER:   read_reg = regs.oper;
			REG_POWER:  read_reg = regs.power;
			REG_ROUTE:  read_reg = regs.route;
			REG_ADAPT:  read_reg = {regs.adapt[7:1], done_flag};
			REG_DROP:   read_reg = regs.drop;
			REG_STATUS: read_reg = {charger_state_field, 2'h0, boost_active, 2'h0, adc_busy};
			default:    read_reg = 8'h00;
		endcase
	endfunction

	assign rise    = scl_in & ~scl_q;
	assign fall    = ~scl_in & scl_q;
	assign start_c = scl_in & scl_q & sda_q & ~sda_in;
	assign stop_c  = scl_in & scl_q & ~sda_q & sda_in;
	assign sda_out = 1'b0;
	assign sda_oe  = drive;

	// Two-wire slave: address, register pointer, then data bytes with auto increment.
	always_comb begin
		next_bst = bst;
		next_bcnt = bcnt;
		next_sh = sh;
		next_ptr = ptr;
		next_kind = kind;
		next_rnw = rnw;
		next_drive = drive;
		wr_en = 1'b0;
		rd_strobe = 1'b0;
		if (start_c) begin
			next_bst = I_RX;
			next_bcnt = 4'h0;
			next_kind = 2'h0;
			next_drive = 1'b0;
		end else if (stop_c) begin
			next_bst = I_IDLE;
			next_drive = 1'b0;
		end else begin
			case (bst)
				I_RX: begin
					if (rise) begin
						next_bcnt = bcnt + 4'h1;
						if (bcnt < 4'h8) next_sh = {sh[6:0], sda_in};
					end
					if (fall && bcnt == 4'h8) begin
						next_drive = 1'b1;
						if (kind == 2'h0) begin
							next_rnw = sh[0];
							if (sh[7:1] != DEV_ADDR) begin
								next_bst = I_IDLE;
								next_drive = 1'b0;
							end
						end else if (kind == 2'h1) begin
							next_ptr = sh;
						end else begin
							wr_en = 1'b1;
						end
					end
					if (fall && bcnt == 4'h9) begin
						next_drive = 1'b0;
						next_bcnt = 4'h0;
						next_kind = (kind == 2'h2) ? 2'h2 : kind + 2'h1;
						if (kind == 2'h2) next_ptr = ptr + 8'h01;
						if (kind == 2'h0 && rnw) begin
							next_bst = I_TX;
							next_sh = read_reg(ptr);
							next_drive = ~next_sh[7];
							rd_strobe = 1'b1;
						end
					end
				end
				I_TX: begin
					if (rise) begin
						next_bcnt = bcnt + 4'h1;
						if (bcnt == 4'h8 && sda_in) next_bst = I_IDLE;
					end
					if (fall) begin
						if (bcnt == 4'h9) begin
							next_ptr = ptr + 8'h01;
							next_sh = read_reg(ptr + 8'h01);
							next_drive = ~next_sh[7];
							next_bcnt = 4'h0;
							rd_strobe = 1'b1;
						end else if (bcnt == 4'h8) begin
							next_drive = 1'b0;
						end else begin
							next_sh = {sh[6:0], 1'b0};
							next_drive = ~sh[6];
						end
					end
				end
				I_IDLE: next_drive = 1'b0;
				default: next_bst = I_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			bst <= I_IDLE;
			bcnt <= 4'h0;
			sh <= 8'h00;
			ptr <= 8'h00;
			kind <= 2'h0;
			rnw <= 1'b0;
			drive <= 1'b0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			bst <= next_bst;
			bcnt <= next_bcnt;
			sh <= next_sh;
			ptr <= next_ptr;
			kind <= next_kind;
			rnw <= next_rnw;
			drive <= next_drive;
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	// Register file; hardware clears of the storage and adapter bits win over a host write.
	always_comb begin
		next_regs = regs;
		if (wr_en) begin
			case (ptr)
				REG_GLOBAL: next_regs.reset_ctl = sh;
				REG_OPER:   next_regs.oper = sh;
				REG_POWER:  next_regs.power = sh;
				REG_ROUTE:  next_regs.route = sh;
				REG_ADAPT:  next_regs.adapt = {sh[7:1], 1'b0};
				REG_DROP:   next_regs.drop = sh;
				default:    next_regs = regs;
			endcase
		end
		if (input_power_present || wake_exit) next_regs.power[B_SHIP] = 1'b0;
		if (pump_done) next_regs.adapt[B_ASIG_EN] = 1'b0;
		if (regs.reset_ctl[B_REG_RESET]) begin
			next_regs = '{RST_GLOBAL, RST_OPER, RST_POWER, RST_ROUTE, RST_ADAPT, RST_DROP};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) regs <= '{RST_GLOBAL, RST_OPER, RST_POWER, RST_ROUTE, RST_ADAPT, RST_DROP};
		else regs <= next_regs;
	end

	// Storage mode: delayed battery switch turn-off, and the short button press that wakes.
	always_comb begin
		next_sst = sst;
		next_scnt = scnt;
		next_pressed = pressed;
		next_wcnt = wcnt;
		wake_exit = 1'b0;
		case (sst)
			S_RUN: begin
				next_scnt = '0;
				if (regs.power[B_SHIP]) next_sst = S_DELAY;
			end
			S_DELAY: begin
				next_scnt = scnt + 1'b1;
				if (scnt == (regs.power[B_SHIP_DLY] ? CNT_W'(SHIP_LONG_CYCLES - 1)
					: CNT_W'(SHIP_SHORT_CYCLES - 1))) next_sst = S_OFF;
			end
			S_OFF: next_scnt = '0;
			default: next_sst = S_RUN;
		endcase
		if (!regs.power[B_SHIP]) next_sst = S_RUN;
		// A press longer than the window is ignored, so a held button never wakes the part.
		if (sst == S_RUN) begin
			next_pressed = 1'b0;
		end else if (wake_q && !wake_button_pin) begin
			next_pressed = 1'b1;
			next_wcnt = '0;
		end else if (pressed) begin
			if (wake_button_pin) begin
				next_pressed = 1'b0;
				wake_exit = (wcnt < CNT_W'(WAKE_CYCLES));
			end else if (wcnt < CNT_W'(WAKE_CYCLES)) begin
				next_wcnt = wcnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sst <= S_RUN;
			scnt <= '0;
			wcnt <= '0;
			pressed <= 1'b0;
			wake_q <= 1'b1;
		end else begin
			sst <= next_sst;
			scnt <= next_scnt;
			wcnt <= next_wcnt;
			pressed <= next_pressed;
			wake_q <= wake_button_pin;
		end
	end

	// Adapter signalling: PULSE_NUM current pulses, long for up and short for down.
	assign pump_start = wr_en && ptr == REG_ADAPT && sh[B_ASIG_EN] && regs.adapt[B_ASIG_EN] == 1'b0;
	always_comb begin
		next_pst = pst;
		next_pcnt = pcnt + 1'b1;
		next_pn = pn;
		pump_done = 1'b0;
		case (pst)
			P_IDLE: begin
				next_pcnt = '0;
				next_pn = 2'h0;
				if (pump_start) next_pst = P_ON;
			end
			P_ON: if (pcnt == (regs.adapt[B_ASIG_DIR] ? CNT_W'(PULSE_LONG_CYCLES - 1)
				: CNT_W'(PULSE_SHORT_CYCLES - 1))) begin
				next_pst = P_GAP;
				next_pcnt = '0;
				next_pn = pn + 2'h1;
			end
			P_GAP: if (pcnt == CNT_W'(PULSE_GAP_CYCLES - 1)) begin
				next_pcnt = '0;
				next_pst = (pn == PULSE_NUM) ? P_IDLE : P_ON;
				pump_done = (pn == PULSE_NUM);
			end
			default: next_pst = P_IDLE;
		endcase
		if (!regs.adapt[B_ASIG_EN] && !pump_start) next_pst = P_IDLE;
		// A completion in the same cycle as the clearing read is kept.
		next_done_flag = pump_done | (done_flag & ~(rd_strobe && (bst == I_TX ? ptr + 8'h01 : ptr) == REG_ADAPT));
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pst <= P_IDLE;
			pcnt <= '0;
			pn <= 2'h0;
			done_flag <= 1'b0;
		end else begin
			pst <= next_pst;
			pcnt <= next_pcnt;
			pn <= next_pn;
			done_flag <= next_done_flag;
		end
	end

	// Power stage controls, thermal zone and drop compensation, all registered.
	assign ir_mv_x1000 = 21'(charge_current_ma) * 21'(regs.drop[F_RES_LSB+:3]) * 21'(RES_STEP_MOHM);
	assign ir_mv = 11'(ir_mv_x1000 / 21'd1000);
	assign clamp_mv = 11'(regs.drop[F_CLAMP_LSB+:3]) * 11'(CLAMP_STEP_MV);
	always_comb begin
		next_freq = regs.oper[B_FREQ];
		next_boost = regs.oper[B_OP_MODE] & (~regs.oper[B_PIN_EN] | boost_pin);
		next_bus = next_boost & regs.route[B_ROUTE];
		next_mid = next_boost & ~regs.route[B_ROUTE];
		next_irq = next_done_flag;
		next_comp = (ir_mv < clamp_mv) ? ir_mv : clamp_mv;
		// Comparator hysteresis lives in the analog front end; the zone is picked by priority.
		if (cold_t1) next_thermal.zone = Z_COLD;
		else if (hot_t4) next_thermal.zone = Z_HOT;
		else if (cool_t2) next_thermal.zone = Z_COOL;
		else if (warm_t3) next_thermal.zone = Z_WARM;
		else next_thermal.zone = Z_NORMAL;
		next_thermal.charge_stop = cold_t1 | hot_t4;
		next_thermal.current_half = next_thermal.zone == Z_COOL;
		next_thermal.voltage_drop = next_thermal.zone == Z_WARM;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			switch_frequency_select <= 1'b0;
			boost_active <= 1'b0;
			boost_on_bus_rail <= 1'b0;
			boost_on_mid_node <= 1'b0;
			internal_shutdown <= 1'b0;
			battery_switch_off <= 1'b0;
			input_current_pulse <= 1'b0;
			adapter_irq <= 1'b0;
			thermal <= '{Z_NORMAL, 1'b0, 1'b0, 1'b0};
			drop_comp_mv <= 11'h000;
		end else begin
			switch_frequency_select <= next_freq;
			boost_active <= next_boost;
			boost_on_bus_rail <= next_bus;
			boost_on_mid_node <= next_mid;
			internal_shutdown <= next_sst != S_RUN;
			battery_switch_off <= next_sst == S_OFF;
			input_current_pulse <= next_pst == P_ON;
			adapter_irq <= next_irq;
			thermal <= next_thermal;
			drop_comp_mv <= next_comp;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	a_freq_follow: assert property (##1 switch_frequency_select == $past(regs.oper[B_FREQ]))
		else $error("frequency select does not follow register");
	a_boost_soft: assert property (regs.oper[B_OP_MODE] && !regs.oper[B_PIN_EN] |=> boost_active)
		else $error("software boost not started");
	a_boost_pin: assert property (regs.oper[1:0] == 2'b11 && !boost_pin |=> !boost_active)
		else $error("boost ignores control pin");
	a_route_bus: assert property (boost_active |-> boost_on_bus_rail == $past(regs.route[B_ROUTE]))
		else $error("boost output not on bus rail");
	a_route_mid: assert property (boost_on_mid_node |-> boost_active && !boost_on_bus_rail)
		else $error("boost output routing wrong");
	a_ship_enter: assert property ($rose(regs.power[B_SHIP]) |=> internal_shutdown)
		else $error("storage mode did not shut down");
	a_ship_exit: assert property (input_power_present |=> ##1 !internal_shutdown)
		else $error("input power did not end storage mode");
	a_reg_reset: assert property (regs.reset_ctl[B_REG_RESET] |=> regs.power == RST_POWER && regs.oper == RST_OPER)
		else $error("register reset incomplete");
	a_pump_irq: assert property (pump_done |=> adapter_irq)
		else $error("pattern end gave no interrupt");
	a_thermal_stop: assert property (cold_t1 || hot_t4 |=> thermal.charge_stop && !thermal.current_half)
		else $error("charging not stopped outside limits");
	a_cool_half: assert property (!cold_t1 && !hot_t4 && cool_t2 |=> thermal.current_half)
		else $error("cool zone did not halve current");
	c_boost_bus: cover property (boost_on_bus_rail);
	c_ship_off: cover property (battery_switch_off ##1 !internal_shutdown);
	c_pump_done: cover property (pump_done);
	c_warm: cover property (thermal.voltage_drop);
endmodule

// ===== tb/host_bus_model.sv
// Host-side two-wire master model that reaches the charger registers.
`timescale 1ns/1ps
module host_bus_model #(
	parameter logic [6:0] ADDR = 7'h5a // Arbitrary value.
) (
	// Clock.
	input  wire logic clk_sys,
	// Device side of the data wire.
	input  wire logic sda_oe,
	input  wire logic sda_out,
	// Resolved wires.
	output logic      scl,
	output logic      sda
);
	logic       pull_low;
	logic       nack;
	logic [7:0] rd_byte;
	logic       got;

	// The wire has a pull-up, so a released line reads high, never the last value.
	assign sda = !(pull_low | (sda_oe & !sda_out));
	initial begin
		scl = 1'h1;
		pull_low = 1'h0;
		nack = 1'h0;
		rd_byte = 8'h00;
	end
	// Each clock phase lasts three system cycles; data is sampled at the edge before the fall.
	task automatic half(input logic s);
		repeat (3) @(posedge clk_sys);
		got = sda;
		#1 scl = s;
	endtask
	task automatic start();
		pull_low = 1'h0;
		half(1'h1);
		half(1'h1);
		pull_low = 1'h1;
		half(1'h0);
	endtask
	task automatic stop();
		pull_low = 1'h1;
		half(1'h1);
		half(1'h1);
		pull_low = 1'h0;
		half(1'h1);
	endtask
	// Eight bits MSB first, then the ninth clock with the line released.
	task automatic xfer(input logic [7:0] d, input logic chk);
		for (int i = 7; i >= 0; i--) begin
			pull_low = !d[i];
			half(1'h1);
			half(1'h0);
			rd_byte[i] = got;
		end
		pull_low = 1'h0;
		half(1'h1);
		half(1'h0);
		if (chk) nack |= got;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
		nack = 1'h0;
		start();
		xfer({a, 1'h0}, 1'h1);
		xfer(r, 1'h1);
		xfer(d, 1'h1);
		stop();
	endtask
	// A read ends with a released ninth bit, which the device takes as the last byte.
	task automatic rd(input logic [7:0] r);
		nack = 1'h0;
		start();
		xfer({ADDR, 1'h0}, 1'h1);
		xfer(r, 1'h1);
		start();
		xfer({ADDR, 1'h1}, 1'h1);
		xfer(8'hff, 1'h0);
		stop();
	endtask
endmodule

// ===== tb/tb_charger_mode_control.sv
// Self-checking bench for the charger mode control block.
`timescale 1ns/1ps
module tb_charger_mode_control import charger_mode_pkg::*;;
	localparam logic [6:0] ADDR = 7'h5a; // Arbitrary value.
	localparam int WK = 20, SS = 30, SL = 60, PL = 16, PS = 8, PG = 12;
	localparam logic [7:0] REGS [6] = '{REG_GLOBAL, REG_OPER, REG_POWER, REG_ROUTE, REG_ADAPT, REG_DROP};
	localparam logic [11:0] ZT [6] = '{{4'h0, Z_NORMAL, 3'h0}, {4'h4, Z_COOL, 3'h2}, {4'hc, Z_COLD, 3'h4},
		{4'h2, Z_WARM, 3'h1}, {4'h3, Z_HOT, 3'h4}, {4'hf, Z_COLD, 3'h4}};
	typedef struct {string name; logic [15:0] exp;} note_t;
	note_t       notes[$];
	event        result_ev;
	int          n_mismatch = 0;
	int          checked = 0;
	int          got;
	logic [31:0] seed = 32'h6d53;
	logic        clk_sys = 1'h0, reset = 1'h1, scl, sda, sda_out, sda_oe;
	logic        boost_pin = 1'h0, wake_button_pin = 1'h1, input_power_present = 1'h0;
	logic        cold_t1 = 1'h0, cool_t2 = 1'h0, warm_t3 = 1'h0, hot_t4 = 1'h0, adc_busy = 1'h0;
	logic [1:0]  charger_state_field = 2'h0;
	logic [12:0] charge_current_ma = 13'h0;
	logic        switch_frequency_select, boost_active, boost_on_bus_rail, boost_on_mid_node;
	logic        internal_shutdown, battery_switch_off, input_current_pulse, adapter_irq;
	thermal_t    thermal;
	logic [10:0] drop_comp_mv;

	always #20 clk_sys = !clk_sys;

	// Short counts keep storage and pulse sequences within a few hundred cycles.
	charger_mode_control #(.DEV_ADDR(ADDR), .WAKE_CYCLES(WK), .SHIP_SHORT_CYCLES(SS), .SHIP_LONG_CYCLES(SL),
		.PULSE_LONG_CYCLES(PL), .PULSE_SHORT_CYCLES(PS), .PULSE_GAP_CYCLES(PG)) charger_mode_control_inst (
		.clk_sys(clk_sys), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.boost_pin(boost_pin), .wake_button_pin(wake_button_pin), .input_power_present(input_power_present),
		.cold_t1(cold_t1), .cool_t2(cool_t2), .warm_t3(warm_t3), .hot_t4(hot_t4),
		.charger_state_field(charger_state_field), .adc_busy(adc_busy), .charge_current_ma(charge_current_ma),
		.switch_frequency_select(switch_frequency_select), .boost_active(boost_active),
		.boost_on_bus_rail(boost_on_bus_rail), .boost_on_mid_node(boost_on_mid_node),
		.internal_shutdown(internal_shutdown), .battery_switch_off(battery_switch_off),
		.input_current_pulse(input_current_pulse), .adapter_irq(adapter_irq), .thermal(thermal),
		.drop_comp_mv(drop_comp_mv));
	host_bus_model #(.ADDR(ADDR)) host_bus_model_inst (.clk_sys(clk_sys), .sda_oe(sda_oe),
		.sda_out(sda_out), .scl(scl), .sda(sda));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Maps a result name to the live value it stands for.
	function automatic logic [15:0] seen(string n);
		case (n)
			"rd":    return 16'(host_bus_model_inst.rd_byte);
			"ack":   return 16'(host_bus_model_inst.nack);
			"got":   return 16'(got);
			"freq":  return 16'(switch_frequency_select);
			"boost": return 16'(boost_active);
			"bus":   return 16'(boost_on_bus_rail);
			"mid":   return 16'(boost_on_mid_node);
			"shut":  return 16'(internal_shutdown);
			"off":   return 16'(battery_switch_off);
			"pulse": return 16'(input_current_pulse);
			"irq":   return 16'(adapter_irq);
			"therm": return 16'(thermal);
			default: return 16'(drop_comp_mv);
		endcase
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic note(input string n, input logic [15:0] e);
		notes.push_back('{n, e});
		-> result_ev;
		#1;
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Bounded wait; the count of cycles spent is handed back.
	task automatic wait_for(input string n, input logic [15:0] v, input int lim, output int c);
		c = 0;
		while (seen(n) !== v) begin
			if (c == lim) begin
				n_mismatch++;
				$display("wrong value %s expected %h seen %h", n, v, seen(n));
				stop_test();
			end
			cyc(1);
			c++;
		end
	endtask
	// Takes every queued expectation, oldest first, each time a result is flagged.
	always @(result_ev) begin
		note_t t;
		while (notes.size() > 0) begin
			t = notes.pop_front();
			checked++;
			if (seen(t.name) !== t.exp) begin
				n_mismatch++;
				$display("wrong value %s expected %h seen %h", t.name, t.exp, seen(t.name));
			end
		end
	end

	initial begin
		int c, k, r, cl;
		logic [1:0] st;
		repeat (20) @(posedge clk_sys);
		#1 reset = 1'h0;
		cyc(2);
		// Every control register starts at its default.
		foreach (REGS[i]) begin
			host_bus_model_inst.rd(REGS[i]);
			note("rd", 16'h0);
		end
		// Frequency select with boost off and on, routing, then pin control.
		host_bus_model_inst.wr(ADDR, REG_OPER, 8'h80);
		note("ack", 16'h0);
		note("freq", 16'h1);
		note("boost", 16'h0);
		host_bus_model_inst.wr(ADDR, REG_OPER, 8'h81);
		note("freq", 16'h1);
		note("boost", 16'h1);
		host_bus_model_inst.wr(ADDR, REG_ROUTE, 8'h02);
		note("bus", 16'h1);
		note("mid", 16'h0);
		host_bus_model_inst.wr(ADDR, REG_ROUTE, 8'h00);
		note("bus", 16'h0);
		note("mid", 16'h1);
		host_bus_model_inst.wr(ADDR, REG_OPER, 8'h03);
		note("boost", 16'h0);
		boost_pin = 1'h1;
		cyc(3);
		note("boost", 16'h1);
		// Status follows its sources; writes to it and to an unmapped place change nothing.
		st = 2'(rnd());
		charger_state_field = st;
		adc_busy = 1'(rnd());
		host_bus_model_inst.wr(ADDR, REG_STATUS, 8'hff);
		host_bus_model_inst.wr(ADDR, 8'h03, 8'hff);
		host_bus_model_inst.rd(REG_STATUS);
		note("rd", {8'h0, st, 2'h0, 1'h1, 2'h0, adc_busy});
		host_bus_model_inst.wr(ADDR ^ 7'h01, REG_OPER, 8'h00);
		note("ack", 16'h1);
		host_bus_model_inst.rd(REG_OPER);
		note("rd", 16'h03);
		boost_pin = 1'h0;
		// Storage entry with both delays, left by each of the four ways.
		for (int m = 0; m < 4; m++) begin
			fork
				host_bus_model_inst.wr(ADDR, REG_POWER, {1'h1, m[0], 6'h0});
				begin
					wait_for("shut", 16'h1, 200, c);
					wait_for("off", 16'h1, SL + 5, c);
				end
			join
			k = m[0] ? SL : SS;
			got = int'(c >= k - 1 && c <= k + 2);
			note("got", 16'h1);
			case (m)
				0: begin
					input_power_present = 1'h1;
					cyc(3);
					input_power_present = 1'h0;
				end
				1: host_bus_model_inst.wr(ADDR, REG_POWER, 8'h00);
				2: begin
					wake_button_pin = 1'h0;
					cyc(WK + 5);
					wake_button_pin = 1'h1;
					cyc(4);
					note("shut", 16'h1);
					wake_button_pin = 1'h0;
					cyc(5);
					wake_button_pin = 1'h1;
				end
				default: host_bus_model_inst.wr(ADDR, REG_GLOBAL, 8'h80);
			endcase
			wait_for("shut", 16'h0, 40, c);
			cyc(2);
			note("off", 16'h0);
			if (m != 2) begin
				host_bus_model_inst.rd(REG_POWER);
				note("rd", 16'h0);
			end
		end
		host_bus_model_inst.rd(REG_OPER);
		note("rd", 16'h0);
		// Down then up pulse patterns, each followed by the completion flag.
		for (int d = 0; d < 2; d++) begin
			fork
				host_bus_model_inst.wr(ADDR, REG_ADAPT, {1'h1, d[0], 6'h0});
				for (int p = 0; p < 3; p++) begin
					wait_for("pulse", 16'h1, 300, c);
					wait_for("pulse", 16'h0, 300, got);
					note("got", 16'(d ? PL : PS));
				end
			join
			wait_for("irq", 16'h1, PG + 10, c);
			host_bus_model_inst.rd(REG_ADAPT);
			note("rd", {8'h0, 1'h0, d[0], 6'h01});
			cyc(2);
			note("irq", 16'h0);
		end
		// Six comparator patterns, including the priority of cold over the rest.
		foreach (ZT[i]) begin
			{cold_t1, cool_t2, warm_t3, hot_t4} = ZT[i][11:8];
			cyc(3);
			note("therm", 16'(ZT[i][7:0]));
		end
		// Currents in 40 mA steps make current times resistance a whole number of millivolts.
		repeat (4) begin
			k = int'(rnd() % 205);
			r = int'(rnd() % 8);
			cl = int'(rnd() % 8);
			charge_current_ma = 13'(40 * k);
			host_bus_model_inst.wr(ADDR, REG_DROP, 8'(r * 8 + cl));
			cyc(3);
			note("drop", 16'((k * r < cl * 32) ? k * r : cl * 32));
		end
		stop_test();
	end
endmodule
